// ### hdl/ptac_regs.sv
`timescale 1ns/1ps
// Overview of operation
// [RULE_01] Bit 0 enables serial input equalizer
// [RULE_02] Two-bit boost: normal, five, ten percent
// [RULE_03] Loopback feeds decoded receive data to transmit
// [RULE_04] Software loopback only in plesiochronous/loop modes; lbk_o follows BIT_LBK in every tx_mode, unchecked
// [RULE_05] Mode bit set: coded coax path active
// [RULE_06] Mode bit clear: optical NRZ path active
// [RULE_07] Bit 4 reports receive loss of signal
// [RULE_08] Receive lock lost beyond frequency tolerance
// [RULE_09] Software trusts lock bit only with signal
// [RULE_10] Transmit lock lost when serial input invalid
// [RULE_11] FIFO error set when FIFO hits limit
// [RULE_12] FIFO error cleared by FIFO reset
// [RULE_13] Status bits clear on read
// [RULE_14] Offsets six and seven read zero
// [RULE_15] FIFO reset recentres FIFO pointers
// [RULE_16] Alarm override forces alarms low, resets counters
// [RULE_17] Mode code 11 selects loop timing
// [RULE_18] Software writes reserved bits back unchanged
module ptac_regs
    import ptac_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic [5:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [5:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic rx_signal_lost,
    input wire logic rx_lock_lost,
    input wire logic tx_input_lock_lost,
    input wire logic tx_fifo_phase_error,
    output logic tx_input_equalizer_enable,
    output logic [1:0] driver_amplitude_boost,
    output logic full_digital_loopback_enable,
    output logic coded_path_enable,
    output logic nrz_output_enable,
    output logic tx_fifo_pointer_reset,
    output logic rx_alarm_override,
    output logic rx_alarm_counter_clear,
    output logic loop_timing_enable,
    output logic [1:0] serial_tx_mode_select,
    output logic irq
);
    typedef struct packed {
        logic aw_full;
        logic [3:0] aw_idx;
        logic w_full;
        logic [7:0] w_data;
        logic w_lane0;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [7:0] rdata;
        logic [1:0] rresp;
        logic aw_rdy;
        logic w_rdy;
        logic ar_rdy;
        logic [7:0] eq_ctrl;
        logic [7:0] boost_lbk;
        logic [7:0] line_mode;
        logic [7:0] sig_ctrl;
        logic [7:0] irq_mask;
        logic [1:0] tx_mode;
        logic [7:0] status_rd_clr;
        logic [7:0] irq_clr;
        logic [7:0] ev_prev;
        logic irq;
        logic eq_o;
        logic [1:0] boost_o;
        logic lbk_o;
        logic coded_o;
        logic nrz_o;
        logic fifo_rst_o;
        logic ovr_o;
        logic loop_o;
    } ptac_regs_s;
    ptac_regs_s st_r;
    ptac_regs_s st_nxt;
    logic [3:0] ev_sync;
    logic [7:0] events;
    logic [7:0] status_q;
    logic [7:0] irq_stat_q;
    ptac_sync2 #(.WIDTH(4)) u_sync (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .async_in({rx_signal_lost, rx_lock_lost, tx_input_lock_lost, tx_fifo_phase_error}),
        .sync_out(ev_sync)
    );
    always_comb begin
        events = '0;
        // Override masks both receive alarms
        events[BIT_RX_SIGNAL_LOST] = ev_sync[3] & ~st_r.sig_ctrl[BIT_ALARM_OVR]; // [RULE_07] [RULE_16]
        events[BIT_RX_LOCK_LOST] = ev_sync[2] & ~st_r.sig_ctrl[BIT_ALARM_OVR]; // [RULE_08] [RULE_16]
        events[BIT_TX_INPUT_LOCK_LOST] = ev_sync[1]; // [RULE_10]
        events[BIT_TX_FIFO_PHASE_ERROR] = ev_sync[0] & ~st_r.sig_ctrl[BIT_FIFO_RST]; // [RULE_11]
    end
    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_flag
            if (STATUS_USED[g]) begin : g_used
                // Read-clear status and W1C interrupt status share the event
                ptac_sticky_flag u_stat (
                    .sys_clk(sys_clk),
                    .reset_n(reset_n),
                    .set_i(events[g]),
                    .clear_i(st_r.status_rd_clr[g]),
                    .force_clear_i((g == BIT_TX_FIFO_PHASE_ERROR) ? st_r.sig_ctrl[BIT_FIFO_RST] : 1'b0),
                    .flag(status_q[g])
                ); // [RULE_13] [RULE_12]
                ptac_sticky_flag u_irq (
                    .sys_clk(sys_clk),
                    .reset_n(reset_n),
                    .set_i(events[g] & ~st_r.ev_prev[g]),
                    .clear_i(st_r.irq_clr[g]),
                    .force_clear_i(1'b0),
                    .flag(irq_stat_q[g])
                );
            end else begin : g_unused
                assign status_q[g] = 1'b0;
                assign irq_stat_q[g] = 1'b0;
            end
        end
    endgenerate
    always_comb begin
        logic [7:0] rd;
        logic rd_ok;
        rd = '0;
        rd_ok = 1'b1;
        st_nxt = st_r;
        st_nxt.status_rd_clr = '0;
        st_nxt.irq_clr = '0;
        st_nxt.ev_prev = events;
        if (s_axi_awvalid && !st_r.aw_full) begin
            st_nxt.aw_full = 1'b1;
            st_nxt.aw_idx = s_axi_awaddr[5:2];
        end
        if (s_axi_wvalid && !st_r.w_full) begin
            st_nxt.w_full = 1'b1;
            st_nxt.w_data = s_axi_wdata[7:0];
            st_nxt.w_lane0 = s_axi_wstrb[0];
        end
        if (st_r.bvalid && s_axi_bready) begin
            st_nxt.bvalid = 1'b0;
        end
        if (st_r.aw_full && st_r.w_full && !st_r.bvalid) begin
            st_nxt.aw_full = 1'b0;
            st_nxt.w_full = 1'b0;
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp = AXI_OKAY;
            unique case (st_r.aw_idx)
                IDX_EQ_CTRL: if (st_r.w_lane0) st_nxt.eq_ctrl = st_r.w_data;
                IDX_BOOST_LBK: if (st_r.w_lane0) st_nxt.boost_lbk = st_r.w_data;
                IDX_LINE_MODE: if (st_r.w_lane0) st_nxt.line_mode = st_r.w_data;
                IDX_SIG_CTRL: if (st_r.w_lane0) st_nxt.sig_ctrl = st_r.w_data;
                IDX_IRQ_MASK: if (st_r.w_lane0) st_nxt.irq_mask = st_r.w_data;
                IDX_TX_MODE: if (st_r.w_lane0) st_nxt.tx_mode = st_r.w_data[1:0];
                IDX_IRQ_STAT: if (st_r.w_lane0) st_nxt.irq_clr = st_r.w_data;
                IDX_STATUS, IDX_TEST_A, IDX_TEST_B: ; // Writes ignored
                default: st_nxt.bresp = AXI_SLVERR;
            endcase
        end
        if (st_r.rvalid && s_axi_rready) begin
            st_nxt.rvalid = 1'b0;
        end
        if (s_axi_arvalid && !st_r.rvalid) begin
            unique case (s_axi_araddr[5:2])
                IDX_EQ_CTRL: rd = st_r.eq_ctrl;
                IDX_BOOST_LBK: rd = st_r.boost_lbk;
                IDX_LINE_MODE: rd = st_r.line_mode;
                IDX_STATUS: rd = status_q;
                IDX_TEST_A, IDX_TEST_B: rd = RST_ZERO; // [RULE_14]
                IDX_SIG_CTRL: rd = st_r.sig_ctrl;
                IDX_IRQ_STAT: rd = irq_stat_q;
                IDX_IRQ_MASK: rd = st_r.irq_mask;
                IDX_TX_MODE: rd = {6'h00, st_r.tx_mode};
                default: rd_ok = 1'b0;
            endcase
            st_nxt.rvalid = 1'b1;
            st_nxt.rdata = rd;
            st_nxt.rresp = rd_ok ? AXI_OKAY : AXI_SLVERR;
            if (s_axi_araddr[5:2] == IDX_STATUS) begin
                // Clear only what was returned, so an event landing now is kept
                st_nxt.status_rd_clr = status_q; // [RULE_13]
            end
        end
        st_nxt.eq_o = st_r.eq_ctrl[BIT_EQ_EN]; // [RULE_01]
        // Reserved boost code treated as normal level
        st_nxt.boost_o = (st_r.boost_lbk[BIT_BOOST_LO +: 2] == BOOST_TEST_RESERVED_A) ? BOOST_NORMAL
                         : st_r.boost_lbk[BIT_BOOST_LO +: 2]; // [RULE_02]
        st_nxt.lbk_o = st_r.boost_lbk[BIT_LBK]; // [RULE_03]
        st_nxt.coded_o = st_r.line_mode[BIT_LINE_CODED]; // [RULE_05]
        st_nxt.nrz_o = ~st_r.line_mode[BIT_LINE_CODED]; // [RULE_06]
        st_nxt.fifo_rst_o = st_r.sig_ctrl[BIT_FIFO_RST]; // [RULE_15]
        st_nxt.ovr_o = st_r.sig_ctrl[BIT_ALARM_OVR]; // [RULE_16]
        st_nxt.loop_o = (st_r.tx_mode == SMODE_LOOP_TIMED); // [RULE_17]
        st_nxt.irq = |(irq_stat_q & st_r.irq_mask);
        // Ready flags kept as flops so the bus sees no gate after a register
        st_nxt.aw_rdy = ~st_nxt.aw_full;
        st_nxt.w_rdy = ~st_nxt.w_full;
        st_nxt.ar_rdy = ~st_nxt.rvalid;
    end
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            st_r <= '0;
            st_r.boost_lbk <= RST_BOOST_LBK;
            st_r.eq_ctrl <= RST_EQ_CTRL;
            st_r.line_mode <= RST_LINE_MODE;
            st_r.coded_o <= 1'b1;
            st_r.aw_rdy <= 1'b1;
            st_r.w_rdy <= 1'b1;
            st_r.ar_rdy <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end
    assign s_axi_awready = st_r.aw_rdy;
    assign s_axi_wready = st_r.w_rdy;
    assign s_axi_bvalid = st_r.bvalid;
    assign s_axi_bresp = st_r.bresp;
    assign s_axi_arready = st_r.ar_rdy;
    assign s_axi_rvalid = st_r.rvalid;
    assign s_axi_rdata = {24'h000000, st_r.rdata};
    assign s_axi_rresp = st_r.rresp;
    assign tx_input_equalizer_enable = st_r.eq_o;
    assign driver_amplitude_boost = st_r.boost_o;
    assign full_digital_loopback_enable = st_r.lbk_o;
    assign coded_path_enable = st_r.coded_o;
    assign nrz_output_enable = st_r.nrz_o;
    assign tx_fifo_pointer_reset = st_r.fifo_rst_o;
    assign rx_alarm_override = st_r.ovr_o;
    assign rx_alarm_counter_clear = st_r.ovr_o;
    assign loop_timing_enable = st_r.loop_o;
    assign serial_tx_mode_select = st_r.tx_mode;
    assign irq = st_r.irq;
endmodule : ptac_regs

// ### hdl/ptac_pkg.sv
package ptac_pkg;
    // Register indices; byte address is four times the index
    localparam logic [3:0] IDX_EQ_CTRL = 4'h2;
    localparam logic [3:0] IDX_BOOST_LBK = 4'h3;
    localparam logic [3:0] IDX_LINE_MODE = 4'h4;
    localparam logic [3:0] IDX_STATUS = 4'h5;
    localparam logic [3:0] IDX_TEST_A = 4'h6;
    localparam logic [3:0] IDX_TEST_B = 4'h7;
    localparam logic [3:0] IDX_SIG_CTRL = 4'h8;
    localparam logic [3:0] IDX_IRQ_STAT = 4'h9;
    localparam logic [3:0] IDX_IRQ_MASK = 4'ha;
    localparam logic [3:0] IDX_TX_MODE = 4'hb;
    // Reset values
    localparam logic [7:0] RST_EQ_CTRL = 8'h00;
    localparam logic [7:0] RST_BOOST_LBK = 8'ha8;
    localparam logic [7:0] RST_LINE_MODE = 8'h80;
    localparam logic [7:0] RST_ZERO = 8'h00;
    // Field positions
    localparam int BIT_EQ_EN = 0;
    localparam int BIT_LBK = 0;
    localparam int BIT_BOOST_LO = 1;
    localparam int BIT_LINE_CODED = 7;
    localparam int BIT_TX_FIFO_PHASE_ERROR = 0;
    localparam int BIT_TX_INPUT_LOCK_LOST = 1;
    localparam int BIT_RX_LOCK_LOST = 3;
    localparam int BIT_RX_SIGNAL_LOST = 4;
    localparam int BIT_FIFO_RST = 0;
    localparam int BIT_ALARM_OVR = 5;
    localparam logic [7:0] STATUS_USED = 8'h1b;
    // Boost, serial mode and AXI response encodings
    localparam logic [1:0] BOOST_NORMAL = 2'h0;
    localparam logic [1:0] BOOST_5PCT = 2'h1;
    localparam logic [1:0] BOOST_TEST_RESERVED_A = 2'h2;
    localparam logic [1:0] BOOST_10PCT = 2'h3;
    localparam logic [1:0] SMODE_LOOP_TIMED = 2'h3;
    localparam logic [1:0] SMODE_PLESIO = 2'h1;
    localparam logic [1:0] AXI_OKAY = 2'h0;
    localparam logic [1:0] AXI_SLVERR = 2'h2;
endpackage : ptac_pkg

// ### hdl/ptac_sync2.sv
`timescale 1ns/1ps
module ptac_sync2
    import ptac_pkg::*;
#(
    parameter int WIDTH = 4
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } ptac_sync_s;
    ptac_sync_s st_r;
    ptac_sync_s st_nxt;
    if (WIDTH < 1) begin : g_bad_width
        $error("ptac_sync2 needs a WIDTH of at least one");
    end
    always_comb begin
        st_nxt.meta = async_in;
        st_nxt.stable = st_r.meta;
    end
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
    assign sync_out = st_r.stable;
endmodule : ptac_sync2

// ### hdl/ptac_sticky_flag.sv
`timescale 1ns/1ps
module ptac_sticky_flag
    import ptac_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic set_i,
    input wire logic clear_i,
    input wire logic force_clear_i,
    output logic flag
);
    typedef struct packed {
        logic flag;
    } ptac_flag_s;
    ptac_flag_s st_r;
    ptac_flag_s st_nxt;
    always_comb begin
        st_nxt = st_r;
        // Set beats software clear so no event is lost
        if (set_i) begin
            st_nxt.flag = 1'b1;
        end else if (clear_i) begin
            st_nxt.flag = 1'b0;
        end
        if (force_clear_i) begin
            st_nxt.flag = 1'b0;
        end
    end
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
    assign flag = st_r.flag;
endmodule : ptac_sticky_flag

// ### verification/ptac_regs_props.sv
`timescale 1ns/1ps
module ptac_regs_props
    import ptac_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [1:0] driver_amplitude_boost,
    input wire logic coded_path_enable,
    input wire logic nrz_output_enable,
    input wire logic rx_alarm_override,
    input wire logic rx_alarm_counter_clear,
    input wire logic loop_timing_enable,
    input wire logic [1:0] serial_tx_mode_select
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    sequence s_wr_both;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    property p_wr_answer;
        s_wr_both |-> ##[1:2] s_axi_bvalid;
    endproperty
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
    endproperty
    property p_rd_answer;
        s_rd_take |=> s_axi_rvalid && s_axi_rdata[31:8] == 24'h0;
    endproperty
    property p_r_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    property p_line_path;
        nrz_output_enable == !coded_path_enable;
    endproperty
    property p_boost_code;
        driver_amplitude_boost != BOOST_TEST_RESERVED_A;
    endproperty
    // Decoded output lags the mode register by one cycle
    property p_loop_timing;
        loop_timing_enable == ($past(serial_tx_mode_select) == SMODE_LOOP_TIMED);
    endproperty
    property p_override;
        rx_alarm_counter_clear == rx_alarm_override;
    endproperty
    a_wr_answer: assert property (p_wr_answer) else $error("write answer late");
    a_b_hold: assert property (p_b_hold) else $error("bvalid dropped");
    a_rd_answer: assert property (p_rd_answer) else $error("read answer bad");
    a_r_hold: assert property (p_r_hold) else $error("read data unstable");
    a_line_path: assert property (p_line_path) else $error("line path clash");
    a_boost_code: assert property (p_boost_code) else $error("reserved boost");
    a_loop_timing: assert property (p_loop_timing) else $error("loop timing");
    a_override: assert property (p_override) else $error("override counters");
endmodule : ptac_regs_props
bind ptac_regs ptac_regs_props u_props (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .driver_amplitude_boost(driver_amplitude_boost),
    .coded_path_enable(coded_path_enable),
    .nrz_output_enable(nrz_output_enable),
    .rx_alarm_override(rx_alarm_override),
    .rx_alarm_counter_clear(rx_alarm_counter_clear),
    .loop_timing_enable(loop_timing_enable),
    .serial_tx_mode_select(serial_tx_mode_select)
);

// ### verification/tb.sv
`timescale 1ns/1ps
module tb import ptac_pkg::*;;
    logic sys_clk = 0, reset_n = 0;
    logic [5:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, driver_amplitude_boost, serial_tx_mode_select;
    logic rx_signal_lost = 0, rx_lock_lost = 0, tx_input_lock_lost = 0, tx_fifo_phase_error = 0;
    logic tx_input_equalizer_enable, full_digital_loopback_enable, coded_path_enable;
    logic nrz_output_enable, tx_fifo_pointer_reset, rx_alarm_override, rx_alarm_counter_clear;
    logic loop_timing_enable, irq;
    int fails = 0, tests_run = 0;
    always #2.5 sys_clk = ~sys_clk;
    ptac_regs DUT (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .rx_signal_lost(rx_signal_lost),
        .rx_lock_lost(rx_lock_lost),
        .tx_input_lock_lost(tx_input_lock_lost),
        .tx_fifo_phase_error(tx_fifo_phase_error),
        .tx_input_equalizer_enable(tx_input_equalizer_enable),
        .driver_amplitude_boost(driver_amplitude_boost),
        .full_digital_loopback_enable(full_digital_loopback_enable),
        .coded_path_enable(coded_path_enable),
        .nrz_output_enable(nrz_output_enable),
        .tx_fifo_pointer_reset(tx_fifo_pointer_reset),
        .rx_alarm_override(rx_alarm_override),
        .rx_alarm_counter_clear(rx_alarm_counter_clear),
        .loop_timing_enable(loop_timing_enable),
        .serial_tx_mode_select(serial_tx_mode_select),
        .irq(irq)
    );
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : report_and_stop
    task automatic bad(input string msg);
        fails++;
        $display("mismatch at %0t: %s", $time, msg);
    endtask : bad
    task automatic wr(input logic [3:0] idx, input logic [7:0] d, input logic [1:0] er = AXI_OKAY);
        int n = 0;
        s_axi_awaddr <= {idx, 2'b00};
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        do begin
            @(posedge sys_clk);
            n++;
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
        end while (s_axi_bvalid !== 1'b1 && n < 100);
        s_axi_bready <= 0;
        if (s_axi_bvalid !== 1'b1) begin
            bad("write timeout");
            report_and_stop();
        end else begin
            tests_run++;
            if (s_axi_bresp !== er) bad("write response");
            @(posedge sys_clk);
        end
    endtask : wr
    task automatic rd(input logic [3:0] idx, input logic [7:0] e, input logic [1:0] er = AXI_OKAY);
        int n = 0;
        s_axi_araddr <= {idx, 2'b00};
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        do begin
            @(posedge sys_clk);
            n++;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 0;
        end while (s_axi_rvalid !== 1'b1 && n < 100);
        s_axi_rready <= 0;
        if (s_axi_rvalid !== 1'b1) begin
            bad("read timeout");
            report_and_stop();
        end else begin
            tests_run++;
            if (s_axi_rresp !== er || (er == AXI_OKAY && s_axi_rdata !== {24'h0, e}))
                bad($sformatf("read %0h got %h exp %h", idx, s_axi_rdata, e));
            @(posedge sys_clk);
        end
    endtask : rd
    task automatic pin(input logic [1:0] got, input logic [1:0] e, input string what);
        tests_run++;
        if (got !== e) bad(what);
    endtask : pin
    task automatic events(input logic [3:0] ev);
        {rx_signal_lost, rx_lock_lost, tx_input_lock_lost, tx_fifo_phase_error} <= ev;
        repeat (6) @(posedge sys_clk);
    endtask : events
    initial begin
        repeat (20000) @(posedge sys_clk);
        bad("run timeout");
        report_and_stop();
    end
    initial begin
        logic [3:0] ev;
        repeat (4) @(posedge sys_clk);
        reset_n <= 1;
        @(posedge sys_clk);
        pin(coded_path_enable, 1, "coded reset");
        pin(nrz_output_enable, 0, "nrz reset");
        rd(IDX_EQ_CTRL, RST_EQ_CTRL);
        rd(IDX_BOOST_LBK, RST_BOOST_LBK);
        rd(IDX_LINE_MODE, RST_LINE_MODE);
        rd(IDX_STATUS, 8'h00);
        wr(IDX_EQ_CTRL, 8'h01);
        pin(tx_input_equalizer_enable, 1, "equalizer on");
        rd(IDX_EQ_CTRL, 8'h01);
        wr(IDX_EQ_CTRL, 8'h00);
        pin(tx_input_equalizer_enable, 0, "equalizer off");
        // Lane zero strobe low must leave the register alone
        s_axi_wstrb <= 4'h0;
        wr(IDX_EQ_CTRL, 8'h01);
        s_axi_wstrb <= 4'hf;
        rd(IDX_EQ_CTRL, 8'h00);
        wr(IDX_TX_MODE, {6'h0, SMODE_PLESIO});
        pin(loop_timing_enable, 0, "plesio mode");
        for (int i = 0; i < 4; i++) begin
            wr(IDX_BOOST_LBK, {5'b10101, i[1:0], i[0]});
            pin(driver_amplitude_boost, (i == 2) ? BOOST_NORMAL : i[1:0], "boost");
            pin(full_digital_loopback_enable, i[0], "loopback");
        end
        wr(IDX_TX_MODE, {6'h0, SMODE_LOOP_TIMED});
        pin(loop_timing_enable, 1, "loop timing");
        pin(serial_tx_mode_select, SMODE_LOOP_TIMED, "mode select");
        wr(IDX_LINE_MODE, 8'h00);
        pin(coded_path_enable, 0, "coded off");
        pin(nrz_output_enable, 1, "nrz on");
        wr(IDX_LINE_MODE, RST_LINE_MODE);
        pin(coded_path_enable, 1, "coded on");
        wr(IDX_TEST_A, 8'hff);
        rd(IDX_TEST_A, 8'h00);
        rd(IDX_TEST_B, 8'h00);
        wr(4'hc, 8'h01, AXI_SLVERR);
        rd(4'hc, 8'h00, AXI_SLVERR);
        // Each event pulsed and gone before the read, so only a sticky bit shows
        for (int k = 0; k < 4; k++) begin
            ev = 4'h1 << k;
            events(ev);
            events(4'h0);
            rd(IDX_STATUS, {3'h0, ev[3:2], 1'b0, ev[1:0]});
            rd(IDX_STATUS, 8'h00);
            wr(IDX_IRQ_MASK, 8'h00);
            pin(irq, 0, "irq masked");
            wr(IDX_IRQ_MASK, 8'hff);
            pin(irq, 1, "irq unmasked");
            wr(IDX_IRQ_STAT, 8'hff);
            // Flag clears one cycle after the write, the output one more
            @(posedge sys_clk);
            pin(irq, 0, "irq clear");
        end
        events(4'h1);
        wr(IDX_SIG_CTRL, 8'h01);
        pin(tx_fifo_pointer_reset, 1, "fifo reset");
        rd(IDX_STATUS, 8'h00);
        events(4'h0);
        wr(IDX_SIG_CTRL, 8'h20);
        pin({rx_alarm_override, rx_alarm_counter_clear}, 2'h3, "override");
        events(4'hc);
        rd(IDX_STATUS, 8'h00);
        events(4'h0);
        wr(IDX_SIG_CTRL, 8'h00);
        // Reset in mid-run, held two edges so the lagging outputs settle first
        reset_n <= 0;
        repeat (2) @(posedge sys_clk);
        reset_n <= 1;
        @(posedge sys_clk);
        pin(loop_timing_enable, 0, "loop after reset");
        rd(IDX_BOOST_LBK, RST_BOOST_LBK);
        rd(IDX_LINE_MODE, RST_LINE_MODE);
        report_and_stop();
    end
endmodule : tb
